// >>> mcid_regs.svh
`ifndef MCID_REGS_SVH
`define MCID_REGS_SVH
// ==========================================
// register offsets (byte addresses)
`define MCID_OFF_CTRL    32'h0000_0000
`define MCID_OFF_INSN    32'h0000_0004
`define MCID_OFF_ACC     32'h0000_0008
`define MCID_OFF_STATUS  32'h0000_000c
`define MCID_OFF_RESULT  32'h0000_0010
`define MCID_OFF_FILEIN  32'h0000_0014
// ==========================================
// status field positions
`define MCID_ST_C        0
`define MCID_ST_DC       1
`define MCID_ST_Z        2
`define MCID_ST_PD       3
`define MCID_ST_TO       4
`define MCID_ST_BUSY     5
// ==========================================
// reset values and timing
`define MCID_ACC_RST     8'h00
`define MCID_QUARTERS    4
`endif

// >>> mcid_pkg.sv
package mcid_pkg;
  // instruction cycle phase
  typedef enum logic [1:0] {
    MCID_IDLE = 2'b00,
    MCID_EXEC = 2'b01,
    MCID_NOP2 = 2'b10
  } mcid_phase_t;

  typedef struct packed {
    mcid_phase_t phase;
    logic [1:0]  quarter;
    logic [13:0] insn;
    logic [7:0]  acc;
    logic [7:0]  result;
    logic [6:0]  faddr;
    logic        to_acc;
    logic        fwrite;
    logic        c;
    logic        dc;
    logic        z;
    logic        to_n;
    logic        pd_n;
    logic        skip_n;
    logic        wdt_clr;
    logic        sleep;
    logic        pre_clr;
    logic        aw_seen;
    logic [31:0] awaddr;
    logic        w_seen;
    logic [31:0] wdata;
    logic        bvalid;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [1:0]  bresp;
  } mcid_state_t;
endpackage : mcid_pkg

// >>> mcid_decoder.sv
`timescale 1ns/1ps
`include "mcid_regs.svh"
module mcid_decoder
  import mcid_pkg::*;
#(
  parameter int          INSN_W   = 14,
  parameter logic [6:0]  TMR_ADDR = 7'h01,
  parameter logic [6:0]  PORT_LO  = 7'h05,
  parameter logic [6:0]  PORT_HI  = 7'h09
) (
  // clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RSTN,
  // axi4-lite write
  input  wire logic [31:0] S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  // axi4-lite read
  input  wire logic [31:0] S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  // core side
  input  wire logic [7:0]  PIN_LEVELS,
  input  wire logic        PRESCALER_TO_TIMER,
  output logic [6:0]       FILE_ADDR,
  output logic             FILE_WRITE,
  output logic [7:0]       FILE_WDATA,
  output logic             WDT_CLEAR,
  output logic             STANDBY,
  output logic             TIMER_PRESCALER_CLEAR
);

  // refuse word widths and port windows the decode cannot serve
  if (INSN_W != 14) begin : g_chk_width
    $error("only 14-bit words supported");
  end
  if (PORT_LO > PORT_HI) begin : g_chk_ports
    $error("port window is empty");
  end

  // ==========================================
  // state
  mcid_state_t s_q;
  mcid_state_t s_d;

  logic [7:0] fval;
  logic [7:0] file_reg_q;
  logic [7:0] alu;
  logic [8:0] sum;
  logic [4:0] hsum;
  logic [7:0] bmask;
  logic [7:0] lit;
  logic       upd_z;
  logic       upd_cdc;
  logic       upd_c;
  logic       two_cyc;
  logic       is_port;
  logic       wr_go;
  logic       go;

  // file value register written by software
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      file_reg_q <= 8'h00;
    end else if (wr_go && s_q.awaddr == `MCID_OFF_FILEIN) begin
      file_reg_q <= s_q.wdata[7:0];
    end
  end

  assign wr_go  = s_q.aw_seen && s_q.w_seen && !s_q.bvalid;
  assign go     = wr_go && s_q.awaddr == `MCID_OFF_CTRL && s_q.wdata[0] && s_q.phase == MCID_IDLE;
  // port reads take pin levels
  assign is_port = s_q.faddr >= PORT_LO && s_q.faddr <= PORT_HI;
  assign fval    = is_port ? PIN_LEVELS : file_reg_q;
  assign bmask   = 8'h01 << s_q.insn[9:7];
  assign lit     = s_q.insn[7:0];

  // ==========================================
  // execute decode
  always_comb begin
    alu     = fval;
    sum     = 9'h000;
    hsum    = 5'h00;
    upd_z   = 1'b0;
    upd_cdc = 1'b0;
    upd_c   = 1'b0;
    two_cyc = 1'b0;
    unique case (s_q.insn[13:12])
      2'b00: begin
        unique case (s_q.insn[11:8])
          4'h7: begin
            sum = {1'b0, fval} + {1'b0, s_q.acc};
            hsum = {1'b0, fval[3:0]} + {1'b0, s_q.acc[3:0]};
            alu = sum[7:0]; upd_cdc = 1'b1; upd_z = 1'b1;
          end
          4'h2: begin
            sum = {1'b0, fval} + {1'b0, ~s_q.acc} + 9'h001;
            hsum = {1'b0, fval[3:0]} + {1'b0, ~s_q.acc[3:0]} + 5'h01;
            alu = sum[7:0]; upd_cdc = 1'b1; upd_z = 1'b1;
          end
          4'h5: begin alu = fval & s_q.acc; upd_z = 1'b1; end
          4'h4: begin alu = fval | s_q.acc; upd_z = 1'b1; end
          4'h6: begin alu = fval ^ s_q.acc; upd_z = 1'b1; end
          4'h9: begin alu = ~fval; upd_z = 1'b1; end
          4'h3: begin alu = fval - 8'h01; upd_z = 1'b1; end
          4'ha: begin alu = fval + 8'h01; upd_z = 1'b1; end
          4'h8: begin alu = fval; upd_z = 1'b1; end
          4'hd: begin alu = {fval[6:0], s_q.c}; upd_c = 1'b1; end
          4'hc: begin alu = {s_q.c, fval[7:1]}; upd_c = 1'b1; end
          4'he: alu = {fval[3:0], fval[7:4]};
          4'hb: begin alu = fval - 8'h01; two_cyc = (alu == 8'h00); end
          4'hf: begin alu = fval + 8'h01; two_cyc = (alu == 8'h00); end
          4'h1: begin alu = 8'h00; upd_z = 1'b1; end
          default: begin
            alu = s_q.acc; // store acc or misc control
            if (s_q.insn[7:4] == 4'h0 && s_q.insn[3:1] == 3'b100) two_cyc = 1'b1;
          end
        endcase
      end
      2'b01: begin
        unique case (s_q.insn[11:10])
          2'b00: alu = fval & ~bmask;
          2'b01: alu = fval | bmask;
          2'b10: two_cyc = (fval & bmask) == 8'h00;
          default: two_cyc = (fval & bmask) != 8'h00;
        endcase
      end
      2'b10: two_cyc = 1'b1;
      default: begin
        unique casez (s_q.insn[11:8])
          4'b111?: begin
            sum = {1'b0, lit} + {1'b0, s_q.acc};
            hsum = {1'b0, lit[3:0]} + {1'b0, s_q.acc[3:0]};
            alu = sum[7:0]; upd_cdc = 1'b1; upd_z = 1'b1;
          end
          4'b110?: begin
            sum = {1'b0, lit} + {1'b0, ~s_q.acc} + 9'h001;
            hsum = {1'b0, lit[3:0]} + {1'b0, ~s_q.acc[3:0]} + 5'h01;
            alu = sum[7:0]; upd_cdc = 1'b1; upd_z = 1'b1;
          end
          4'b1001: begin alu = lit & s_q.acc; upd_z = 1'b1; end
          4'b1000: begin alu = lit | s_q.acc; upd_z = 1'b1; end
          4'b1010: begin alu = lit ^ s_q.acc; upd_z = 1'b1; end
          4'b01??: begin alu = lit; two_cyc = 1'b1; end
          default: alu = lit;
        endcase
      end
    endcase
  end

  // ==========================================
  // next state
  always_comb begin
    s_d = s_q;
    s_d.wdt_clr = 1'b0;
    s_d.sleep   = 1'b0;
    s_d.pre_clr = 1'b0;
    s_d.fwrite  = 1'b0;
    // bus write side
    if (S_AXI_AWVALID && !s_q.aw_seen) begin
      s_d.aw_seen = 1'b1;
      s_d.awaddr  = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !s_q.w_seen) begin
      s_d.w_seen = 1'b1;
      s_d.wdata  = S_AXI_WDATA;
    end
    if (wr_go) begin
      s_d.aw_seen = 1'b0;
      s_d.w_seen  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = 2'b00;
      if (s_q.awaddr == `MCID_OFF_INSN) begin
        s_d.insn  = s_q.wdata[13:0];
        s_d.faddr = s_q.wdata[6:0];
      end else if (s_q.awaddr == `MCID_OFF_ACC) begin
        s_d.acc = s_q.wdata[7:0];
      end else if (s_q.awaddr != `MCID_OFF_CTRL && s_q.awaddr != `MCID_OFF_FILEIN) begin
        s_d.bresp = 2'b10;
      end
    end
    if (s_q.bvalid && S_AXI_BREADY) s_d.bvalid = 1'b0;
    // bus read side
    if (S_AXI_ARVALID && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = 2'b00;
      unique case (S_AXI_ARADDR)
        `MCID_OFF_CTRL:   s_d.rdata = 32'h0000_0000;
        `MCID_OFF_INSN:   s_d.rdata = {18'h00000, s_q.insn};
        `MCID_OFF_ACC:    s_d.rdata = {24'h000000, s_q.acc};
        `MCID_OFF_STATUS: s_d.rdata = {26'h0000000, s_q.phase != MCID_IDLE, s_q.to_n, s_q.pd_n,
                                       s_q.z, s_q.dc, s_q.c};
        `MCID_OFF_RESULT: s_d.rdata = {24'h000000, s_q.result};
        `MCID_OFF_FILEIN: s_d.rdata = {24'h000000, file_reg_q};
        default: begin s_d.rdata = 32'h0000_0000; s_d.rresp = 2'b10; end
      endcase
    end else if (s_q.rvalid && S_AXI_RREADY) begin
      s_d.rvalid = 1'b0;
    end
    // instruction sequencer, four clocks per cycle
    unique case (s_q.phase)
      MCID_IDLE: begin
        s_d.quarter = 2'd0;
        if (go) s_d.phase = MCID_EXEC;
      end
      MCID_EXEC: begin
        s_d.quarter = s_q.quarter + 2'd1;
        if (s_q.quarter == 2'(`MCID_QUARTERS - 1)) begin
          s_d.result = alu;
          s_d.skip_n = !two_cyc;
          if (upd_z) s_d.z = (alu == 8'h00);
          if (upd_cdc) begin
            s_d.c  = sum[8];
            s_d.dc = hsum[4];
          end
          if (upd_c) s_d.c = s_q.insn[8] ? fval[7] : fval[0];
          // destination: file for d=1, bit clear/set, stores
          if (s_q.insn[13:12] == 2'b01) begin
            s_d.fwrite = !s_q.insn[11];
          end else if (s_q.insn[13:12] == 2'b00 && (s_q.insn[11:8] != 4'h0 || s_q.insn[7])) begin
            s_d.fwrite = s_q.insn[7];
            if (!s_q.insn[7]) s_d.acc = alu;
          end else if (s_q.insn[13:12] == 2'b11) begin
            s_d.acc = alu;
          end
          if (s_q.insn == 14'h0064) begin
            s_d.wdt_clr = 1'b1;
            s_d.to_n = 1'b1;
            s_d.pd_n = 1'b1;
          end
          if (s_q.insn == 14'h0063) begin
            s_d.sleep = 1'b1;
            s_d.to_n = 1'b1;
            s_d.pd_n = 1'b0;
            s_d.wdt_clr = 1'b1;
          end
          s_d.pre_clr = s_d.fwrite && s_q.faddr == TMR_ADDR && PRESCALER_TO_TIMER;
          s_d.phase = two_cyc ? MCID_NOP2 : MCID_IDLE;
        end
      end
      MCID_NOP2: begin
        s_d.quarter = s_q.quarter + 2'd1;
        if (s_q.quarter == 2'(`MCID_QUARTERS - 1)) s_d.phase = MCID_IDLE;
      end
      default: s_d.phase = MCID_IDLE;
    endcase
  end

  // ==========================================
  // state register
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      s_q        <= '0;
      s_q.acc    <= `MCID_ACC_RST;
      s_q.to_n   <= 1'b1;
      s_q.pd_n   <= 1'b1;
      s_q.skip_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================
  // outputs
  assign S_AXI_AWREADY         = !s_q.aw_seen;
  assign S_AXI_WREADY          = !s_q.w_seen;
  assign S_AXI_BVALID          = s_q.bvalid;
  assign S_AXI_BRESP           = s_q.bresp;
  assign S_AXI_ARREADY         = !s_q.rvalid;
  assign S_AXI_RVALID          = s_q.rvalid;
  assign S_AXI_RDATA           = s_q.rdata;
  assign S_AXI_RRESP           = s_q.rresp;
  assign FILE_ADDR             = s_q.faddr;
  assign FILE_WRITE            = s_q.fwrite;
  assign FILE_WDATA            = s_q.result;
  assign WDT_CLEAR             = s_q.wdt_clr;
  assign STANDBY               = s_q.sleep;
  assign TIMER_PRESCALER_CLEAR = s_q.pre_clr;

  // ==========================================
  // checks
  sequence exec_end_s;
    s_q.phase == MCID_EXEC && s_q.quarter == 2'd3;
  endsequence

  chk_cycle_len: assert property (@(posedge CLOCK) disable iff (!RSTN)
    $rose(s_q.phase == MCID_EXEC) |-> (s_q.phase == MCID_EXEC) [*4])
    else $error("instruction cycle not four clocks");
  chk_two_cycle: assert property (@(posedge CLOCK) disable iff (!RSTN)
    exec_end_s and two_cyc |=> (s_q.phase == MCID_NOP2) [*4])
    else $error("second cycle missing");
  chk_one_cycle: assert property (@(posedge CLOCK) disable iff (!RSTN)
    exec_end_s and !two_cyc |=> s_q.phase == MCID_IDLE)
    else $error("single cycle overran");
  chk_zero_flag: assert property (@(posedge CLOCK) disable iff (!RSTN)
    exec_end_s and upd_z |=> s_q.z == (s_q.result == 8'h00))
    else $error("Z flag wrong");
  chk_wdt_flags: assert property (@(posedge CLOCK) disable iff (!RSTN)
    WDT_CLEAR && !STANDBY |-> s_q.to_n && s_q.pd_n)
    else $error("watchdog clear flags wrong");
  chk_standby_pd: assert property (@(posedge CLOCK) disable iff (!RSTN)
    STANDBY |-> !s_q.pd_n && s_q.to_n)
    else $error("standby flags wrong");
  chk_acc_dest: assert property (@(posedge CLOCK) disable iff (!RSTN)
    exec_end_s and s_q.insn[13:12] == 2'b00 && s_q.insn[11:8] == 4'h9 |=> FILE_WRITE == $past(s_q.insn[7]))
    else $error("destination select wrong");
  chk_bit_flags: assert property (@(posedge CLOCK) disable iff (!RSTN)
    exec_end_s and s_q.insn[13:12] == 2'b01 |=> $stable(s_q.z) && $stable(s_q.c))
    else $error("bit op touched flags");
  chk_prescaler: assert property (@(posedge CLOCK) disable iff (!RSTN)
    TIMER_PRESCALER_CLEAR |-> FILE_WRITE && FILE_ADDR == TMR_ADDR)
    else $error("prescaler clear without timer write");

endmodule : mcid_decoder

// >>> mcid_prog_mem.sv
`timescale 1ns/1ps
// ==========================================
// program memory model: corner instruction words
module mcid_prog_mem
  import mcid_pkg::*;
(
  // fetch side
  input  wire logic [2:0]  pc,
  output logic      [13:0] word
);
  // one whole 14-bit word per slot, fixed contents
  always_comb begin
    case (pc)
      3'h0: word = 14'h0060;    // no-op with don't-care bits set
      3'h1: word = 14'h0063;    // standby word
      3'h2: word = 14'h0064;    // watchdog clear word
      3'h3: word = 14'h0008;    // subroutine return
      3'h4: word = 14'h0009;    // interrupt return
      3'h5: word = 14'h0a81;    // increment timer count to file
      3'h6: word = 14'h0f85;    // increment port with skip
      default: word = 14'h0180; // clear file 0
    endcase
  end
endmodule : mcid_prog_mem

// >>> tb_mcu_14bit_instruction_decoder.sv
`timescale 1ns/1ps
`include "mcid_regs.svh"
module tb_mcu_14bit_instruction_decoder
  import mcid_pkg::*;
;
  // ==========================================
  // signals
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, fwr, wdc, sb, pcl;
  logic        ptt = 1'b0;
  logic [1:0]  bresp, rresp;
  logic [7:0]  pins = '0, fdat, wd, e_res, e_acc;
  logic [6:0]  fa, wa;
  logic [2:0]  pc = '0, e_fl = '0;
  logic [1:0]  e_st = 2'b11;
  logic [13:0] rom_word;
  logic        e_wr, e_two, e_pc, e_wdc, e_sb;
  int          n_fail = 0, checks = 0, nwr, npc, nwd, nsb;
  integer      seed = 32'ha4768ec0;

  always #4 clock = ~clock;

  mcid_decoder dut_u (
    .CLOCK(clock), .RSTN(rstn),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .PIN_LEVELS(pins), .PRESCALER_TO_TIMER(ptt), .FILE_ADDR(fa), .FILE_WRITE(fwr),
    .FILE_WDATA(fdat), .WDT_CLEAR(wdc), .STANDBY(sb), .TIMER_PRESCALER_CLEAR(pcl)
  );

  mcid_prog_mem prog_u (.pc(pc), .word(rom_word));

  // count core-side pulses of one instruction
  always @(posedge clock) begin
    if (fwr) begin
      nwr++;
      wd = fdat;
      wa = fa;
    end
    npc += pcl;
    nwd += wdc;
    nsb += sb;
  end

  // ==========================================
  // bus tasks and checking
  task automatic axw(input logic [31:0] a, d, output logic [1:0] r);
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      begin do @(posedge clock); while (!awready); awvalid <= 1'b0; end
      begin do @(posedge clock); while (!wready); wvalid <= 1'b0; end
    join
    while (!bvalid) @(posedge clock);
    r = bresp;
    bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clock); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge clock);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axr

  task automatic check(input string what, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  // ==========================================
  // reference model of one instruction
  function automatic logic [9:0] addf(input logic [7:0] a, b, input logic cin);
    logic [8:0] s;
    logic [4:0] h;
    s = a + b + cin;
    h = a[3:0] + b[3:0] + cin;
    return {s[8], h[4], s[7:0]};
  endfunction : addf

  task automatic predict(input logic [13:0] i, input logic [7:0] w, fr, p);
    logic [7:0] f;
    logic [9:0] a;
    f = (i[6:0] >= 7'h05 && i[6:0] <= 7'h09) ? p : fr;
    {e_res, e_acc, e_wr, e_two, e_wdc, e_sb, a} = {8'h00, w, 14'h0000};
    case (i[13:12])
      2'b00: begin
        case (i[11:8])
          4'h0: e_res = w;
          4'h2: a = addf(f, ~w, 1'b1);
          4'h3, 4'hb: e_res = f - 8'h01;
          4'h4: e_res = f | w;
          4'h5: e_res = f & w;
          4'h6: e_res = f ^ w;
          4'h7: a = addf(f, w, 1'b0);
          4'h8: e_res = f;
          4'h9: e_res = ~f;
          4'ha, 4'hf: e_res = f + 8'h01;
          4'hc: {e_res, e_fl[0]} = {e_fl[0], f};
          4'hd: {e_fl[0], e_res} = {f, e_fl[0]};
          4'he: e_res = {f[3:0], f[7:4]};
          default: ;
        endcase
        if (i[11:8] == 4'h2 || i[11:8] == 4'h7) {e_fl[0], e_fl[1], e_res} = a;
        if (i[11:8] inside {[4'h1:4'ha]}) e_fl[2] = (e_res == 8'h00);
        e_two = i[11:8] inside {4'hb, 4'hf} && e_res == 8'h00;
        e_wr = i[7];
        if (!i[7]) e_acc = e_res;
        if (i == 14'h0063 || i == 14'h0064) begin
          e_wdc = 1'b1;
          e_sb = i[0];
          e_st = {1'b1, ~i[0]};
        end
        e_two |= (i == 14'h0008 || i == 14'h0009);
      end
      2'b01: begin
        e_res = i[10] ? (f | (8'h01 << i[9:7])) : (f & ~(8'h01 << i[9:7]));
        e_wr = !i[11];
        e_two = i[11] && (f[i[9:7]] == i[10]);
      end
      2'b10: e_two = 1'b1;
      default: begin
        casez (i[11:8])
          4'b111?: a = addf(w, i[7:0], 1'b0);
          4'b110?: a = addf(i[7:0], ~w, 1'b1);
          4'b1001: e_res = w & i[7:0];
          4'b1000: e_res = w | i[7:0];
          4'b1010: e_res = w ^ i[7:0];
          default: e_res = i[7:0];
        endcase
        if (i[11:10] == 2'b11) {e_fl[0], e_fl[1], e_res} = a;
        if (i[11]) e_fl[2] = (e_res == 8'h00);
        e_two = (i[11:10] == 2'b01);
        e_acc = e_res;
      end
    endcase
    e_pc = e_wr && i[6:0] == 7'h01 && ptt;
  endtask : predict

  // load operands, start, check busy in the second cycle and wait it out, compare everything
  task automatic run_op(input logic [13:0] i, input logic [7:0] w, f, p);
    logic [31:0] d;
    logic [1:0]  r;
    pins <= p;
    ptt <= 1'($random(seed));
    axw(`MCID_OFF_INSN, {18'h0, i}, r);
    axw(`MCID_OFF_ACC, {24'h0, w}, r);
    axw(`MCID_OFF_FILEIN, {24'h0, f}, r);
    predict(i, w, f, p);
    {nwr, npc, nwd, nsb} = '0;
    axw(`MCID_OFF_CTRL, 32'h1, r);
    // status is sampled five edges after the go answer: inside the nop cycle, past the execute cycle
    repeat (3) @(posedge clock);
    axr(`MCID_OFF_STATUS, d, r);
    check("second cycle busy", d[`MCID_ST_BUSY], e_two);
    while (d[`MCID_ST_BUSY] !== 1'b0) axr(`MCID_OFF_STATUS, d, r);
    check("flags", d[2:0], e_fl);
    check("timeout powerdown", d[4:3], e_st);
    axr(`MCID_OFF_ACC, d, r);
    check("acc", d[7:0], e_acc);
    check("file write count", nwr, e_wr);
    if (e_wr) check("file data", wd, e_res);
    if (e_wr) check("file addr", wa, i[6:0]);
    check("prescaler clear", npc, e_pc);
    check("watchdog clear", nwd, e_wdc);
    check("standby", nsb, e_sb);
  endtask : run_op

  // ==========================================
  // main sequence
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [13:0] i;
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    axr(`MCID_OFF_STATUS, d, r);
    check("status reset", d[5:0], 6'h18);
    axr(`MCID_OFF_ACC, d, r);
    check("acc reset", d[7:0], `MCID_ACC_RST);
    axr(32'h0000_0040, d, r);
    check("unmapped read data", d, 32'h0);
    check("unmapped read resp", r, 2'b10);
    axw(32'h0000_0040, 32'h5a, r);
    check("unmapped write", r, 2'b10);
    for (int n = 0; n < 8; n++) begin
      pc <= 3'(n);
      @(posedge clock);
      run_op(rom_word, 8'($random(seed)), 8'hff, 8'hff);
    end
    // every opcode prefix but 6'h3b (run as 6'h3a), three passes with random operands
    for (int n = 0; n < 192; n++) begin
      i = 14'($random(seed));
      i[13:8] = 6'(n);
      if (i[13:8] == 6'h3b) i[8] = 1'b0;
      if (i[13:8] == 6'h00) i[7] = 1'b1;
      run_op(i, 8'($random(seed)), 8'($random(seed)), 8'($random(seed)));
    end
    tally_and_finish();
  end

  // hang guard
  initial begin
    repeat (40000) @(posedge clock);
    n_fail++;
    tally_and_finish();
  end
endmodule : tb_mcu_14bit_instruction_decoder
